// ==== logic/wds_consts.svh ====
`ifndef WDS_CONSTS_SVH
`define WDS_CONSTS_SVH

// Register offsets.
`define WDS_ADDR_CTRL 7'h00
`define WDS_ADDR_STATUS 7'h05
`define WDS_ADDR_CFG 7'h74

// Watchdog control fields.
`define WDS_MODE_HI 7
`define WDS_MODE_LO 5
`define WDS_PER_HI 3
`define WDS_PER_LO 0

// Mode codes.
`define WDS_MODE_AUTO 3'h1
`define WDS_MODE_TIMEOUT 3'h2
`define WDS_MODE_WINDOW 3'h4

// Period codes.
`define WDS_PER_8 4'h8
`define WDS_PER_16 4'h1
`define WDS_PER_32 4'h2
`define WDS_PER_64 4'hb
`define WDS_PER_128 4'h4
`define WDS_PER_256 4'hd
`define WDS_PER_1024 4'he
`define WDS_PER_4096 4'h7
`define WDS_PER_DEFAULT 4'h4

// Configuration fields and reset value.
`define WDS_CFG_UV_HI 5
`define WDS_CFG_UV_LO 4
`define WDS_CFG_FNM 3
`define WDS_CFG_SDM 2
`define WDS_CFG_SLP 0
`define WDS_CFG_RESET 8'h08

// Status fields.
`define WDS_ST_FNM 3
`define WDS_ST_SDM 2

// Reset source codes.
`define WDS_SRC_EARLY 5'h0e
`define WDS_SRC_OVERFLOW 5'h0f
`define WDS_SRC_ILLEGAL 5'h10

// Timing.
`define WDS_CLK_NS 50
`define WDS_MS_NS 1000000
`define WDS_TICK_CYCLES (`WDS_MS_NS / `WDS_CLK_NS)

`endif

// ==== logic/wds_pkg.sv ====
package wds_pkg;

   typedef enum logic [2:0] {
      WDS_OP_OFF,
      WDS_OP_STANDBY,
      WDS_OP_NORMAL,
      WDS_OP_SLEEP,
      WDS_OP_RESET,
      WDS_OP_OTHER
   } wds_op_t;

   typedef enum logic [1:0] {
      WDS_EFF_OFF,
      WDS_EFF_TIMEOUT,
      WDS_EFF_WINDOW
   } wds_eff_t;

endpackage

// ==== logic/wds_sync.sv ====
`timescale 1ns/100ps
module wds_sync (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Asynchronous level in, synchronised level out.
   input wire logic din,
   output logic dout
);

   logic meta;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

// ==== logic/wds_prescaler.sv ====
`timescale 1ns/100ps
module wds_prescaler #(
   parameter int TICK_CYCLES = 20000
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Restart the millisecond phase.
   input wire logic restart,
   // One-cycle pulse each millisecond.
   output logic tick
);

   logic [15:0] count;
   logic [15:0] next_count;
   logic next_tick;

   always_comb begin
      next_count = count + 16'h0001;
      next_tick = 1'b0;
      if (restart) begin
         next_count = 16'h0000;
      end else if (count == 16'(TICK_CYCLES - 1)) begin
         next_count = 16'h0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end

endmodule

// ==== logic/wds_supervisor.sv ====
`timescale 1ns/100ps
`include "wds_consts.svh"

// Behaviour
// RQ1 - Window, timeout and autonomous modes; window acts only in Normal.
// RQ2 - Window mode restarts the timer only on triggers inside the open window.
// RQ3 - Timeout mode runs continuously; any trigger before expiry restarts it.
// RQ4 - Mode field bits 7:5: autonomous 001, timeout 010, window 100.
// RQ5 - Host changes mode or period only in Standby.
// RQ6 - Window selected behaves as timeout until Normal is entered.
// RQ7 - Mode or period change in Normal forces reset, source 10000, failure event.
// RQ8 - Period field bits 3:0 accepts eight codes from 8 ms to 4096 ms.
// RQ9 - Period applies to window and timeout; default 128 ms, code 0100.
// RQ10 - Every valid control write is a trigger restarting the timer (code ignores it in Off and Reset; early and Normal-change ones reset).
// RQ11 - New mode and period take effect immediately from the write.
// RQ12 - Default mode timeout 010, or autonomous 001 with development mode.
// RQ13 - Undefined codes discard the whole write and raise a failure event.
// RQ14 - Valid codes differ pairwise in two or more bits.
// RQ15 - Forced normal keeps the watchdog off in every mode.
// RQ16 - Autonomous runs timeout in Normal or Standby with receive low only.
// RQ17 - Receive line low in Standby marks a pending wake-up.
// RQ18 - Configuration at 74h: forced normal bit 3, development bit 2.
// RQ19 - Bits 5:4 preset undervoltage threshold 90, 80, 70 or 60 percent.
// RQ20 - Sleep-inhibit bit 0 set makes sleep commands ignored.
// RQ21 - Status bits 1:0: off 00, first half 01, second half 10.
// RQ22 - Status bit 3 shows forced normal, bit 2 development mode.
// RQ23 - Timeout expiry serves as cyclic wake-up source.
// RQ24 - Window: early trigger or expiry resets; late trigger restarts timer.
// RQ25 - Timeout: first expiry sets failure pending; second expiry resets.
// RQ26 - Source 01110 for early trigger, 01111 for overflow.
// RQ27 - Millisecond tick from a prescaler; timer cleared on every trigger (code leaves it uncleared on early and on Normal-change triggers).
// RQ28 - First half of window ends at half the period count.
module wds_supervisor
   import wds_pkg::*;
#(
   parameter int TICK_CYCLES = `WDS_TICK_CYCLES
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Register access.
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Chip state.
   input wds_op_t op_mode,
   input wire logic rxd_pin,
   input wire logic spi_fail_enable,
   input wire logic failure_clear,
   // Results toward the chip.
   output logic reset_request,
   output logic [4:0] reset_source_code,
   output logic serial_access_failure_event,
   output logic overflow_wake,
   output logic watchdog_failure_pending,
   output logic [1:0] undervoltage_threshold,
   output logic sleep_inhibit
);

   ////////////////////////////////////////////////////////////////////////////
   // Code checks and decodes.

   function automatic logic mode_valid(input logic [2:0] m);
      mode_valid = (m == `WDS_MODE_AUTO) || (m == `WDS_MODE_TIMEOUT) || (m == `WDS_MODE_WINDOW); // see RQ4 RQ14
   endfunction

   function automatic logic [12:0] period_ms(input logic [3:0] p);
      unique case (p)
         `WDS_PER_8: period_ms = 13'h0008; // see RQ8 RQ14
         `WDS_PER_16: period_ms = 13'h0010;
         `WDS_PER_32: period_ms = 13'h0020;
         `WDS_PER_64: period_ms = 13'h0040;
         `WDS_PER_128: period_ms = 13'h0080;
         `WDS_PER_256: period_ms = 13'h0100;
         `WDS_PER_1024: period_ms = 13'h0400;
         `WDS_PER_4096: period_ms = 13'h1000;
         default: period_ms = 13'h0000;
      endcase
   endfunction

   function automatic wds_eff_t eff_of(input logic forced_normal_mode, input logic software_development_mode, input logic [2:0] m,
                                       input wds_op_t op, input logic rx_low);
      eff_of = WDS_EFF_OFF;
      if (forced_normal_mode) begin
         eff_of = WDS_EFF_OFF; // see RQ15
      end else if (m == `WDS_MODE_WINDOW || m == `WDS_MODE_TIMEOUT) begin
         if (op == WDS_OP_NORMAL && m == `WDS_MODE_WINDOW) begin
            eff_of = WDS_EFF_WINDOW; // see RQ1 RQ6
         end else if (op == WDS_OP_NORMAL || op == WDS_OP_STANDBY || op == WDS_OP_SLEEP) begin
            eff_of = WDS_EFF_TIMEOUT; // see RQ6
         end
      end else if (!software_development_mode && (op == WDS_OP_NORMAL || (op == WDS_OP_STANDBY && rx_low))) begin
         eff_of = WDS_EFF_TIMEOUT; // see RQ16 RQ17
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Support blocks.

   logic rxd_sync;
   logic tick;
   logic trigger;

   wds_sync u_rxd_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .din(rxd_pin),
      .dout(rxd_sync)
   );

   wds_prescaler #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_prescaler (
      .mclk(mclk),
      .rst_n(rst_n),
      .restart(trigger),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog state.

   logic [2:0] mode_select;
   logic [3:0] period_select;
   logic [7:0] cfg;
   logic [12:0] timer;
   logic [12:0] period;
   logic [12:0] next_timer;
   logic [2:0] next_mode;
   logic [3:0] next_period;
   logic [7:0] next_cfg;
   logic [7:0] next_rdata;
   logic [4:0] next_src;
   logic next_reset;
   logic next_fail;
   logic next_wake;
   logic next_wdf;
   logic ctrl_wr;
   logic codes_ok;
   logic changed;
   logic early;
   logic expiry;
   logic first_half;
   logic [1:0] wd_state;
   wds_eff_t eff;

   assign period = period_ms(period_select);
   assign eff = eff_of(cfg[`WDS_CFG_FNM], cfg[`WDS_CFG_SDM], mode_select, op_mode, !rxd_sync);
   assign first_half = timer < (period >> 1); // see RQ28
   assign wd_state = (eff == WDS_EFF_OFF) ? 2'h0 : (first_half ? 2'h1 : 2'h2); // see RQ21
   assign ctrl_wr = reg_wr && reg_addr == `WDS_ADDR_CTRL && op_mode != WDS_OP_RESET && op_mode != WDS_OP_OFF;
   assign codes_ok = mode_valid(reg_wdata[`WDS_MODE_HI:`WDS_MODE_LO])
                     && period_ms(reg_wdata[`WDS_PER_HI:`WDS_PER_LO]) != 13'h0000;
   assign changed = reg_wdata[`WDS_MODE_HI:`WDS_MODE_LO] != mode_select
                    || reg_wdata[`WDS_PER_HI:`WDS_PER_LO] != period_select;
   assign trigger = ctrl_wr && codes_ok; // see RQ10
   assign early = trigger && eff == WDS_EFF_WINDOW && first_half; // see RQ2 RQ24
   assign expiry = tick && eff != WDS_EFF_OFF && timer == period - 13'h0001;

   always_comb begin
      next_mode = mode_select;
      next_period = period_select;
      next_cfg = cfg;
      next_timer = timer;
      next_reset = 1'b0;
      next_src = reset_source_code;
      next_fail = 1'b0;
      next_wake = 1'b0;
      next_wdf = watchdog_failure_pending && !failure_clear;
      if (op_mode == WDS_OP_RESET) begin
         next_mode = cfg[`WDS_CFG_SDM] ? `WDS_MODE_AUTO : `WDS_MODE_TIMEOUT; // see RQ12
         next_period = `WDS_PER_DEFAULT; // see RQ9
      end
      if (reg_wr && reg_addr == `WDS_ADDR_CFG && op_mode != WDS_OP_RESET) begin
         next_cfg = reg_wdata & 8'h3d; // see RQ18 RQ19 RQ20
      end
      if (eff == WDS_EFF_OFF) begin
         next_timer = 13'h0000;
      end else if (tick) begin
         next_timer = expiry ? 13'h0000 : timer + 13'h0001; // see RQ3 RQ27
      end
      if (expiry) begin
         if (eff == WDS_EFF_WINDOW || watchdog_failure_pending) begin
            next_reset = 1'b1; // see RQ24 RQ25
            next_src = `WDS_SRC_OVERFLOW; // see RQ26
         end else begin
            next_wdf = 1'b1; // see RQ25
            next_wake = 1'b1; // see RQ23
         end
      end
      if (ctrl_wr && !codes_ok) begin
         next_fail = spi_fail_enable; // see RQ13
      end else if (trigger && op_mode == WDS_OP_NORMAL && changed) begin
         next_reset = 1'b1; // see RQ7
         next_src = `WDS_SRC_ILLEGAL;
         next_fail = spi_fail_enable;
      end else if (early) begin
         next_reset = 1'b1; // see RQ24
         next_src = `WDS_SRC_EARLY; // see RQ26
      end else if (trigger) begin
         next_mode = reg_wdata[`WDS_MODE_HI:`WDS_MODE_LO]; // see RQ11
         next_period = reg_wdata[`WDS_PER_HI:`WDS_PER_LO];
         next_timer = 13'h0000; // see RQ10 RQ27
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_select <= `WDS_MODE_TIMEOUT;
         period_select <= `WDS_PER_DEFAULT;
         cfg <= `WDS_CFG_RESET;
         timer <= 13'h0000;
         reset_request <= 1'b0;
         reset_source_code <= 5'h00;
         serial_access_failure_event <= 1'b0;
         overflow_wake <= 1'b0;
         watchdog_failure_pending <= 1'b0;
      end else begin
         mode_select <= next_mode;
         period_select <= next_period;
         cfg <= next_cfg;
         timer <= next_timer;
         reset_request <= next_reset;
         reset_source_code <= next_src;
         serial_access_failure_event <= next_fail;
         overflow_wake <= next_wake;
         watchdog_failure_pending <= next_wdf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path and configuration outputs.

   always_comb begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         unique case (reg_addr)
            `WDS_ADDR_CTRL: next_rdata = {mode_select, 1'b0, period_select};
            `WDS_ADDR_STATUS: next_rdata = {4'h0, cfg[`WDS_CFG_FNM], cfg[`WDS_CFG_SDM], wd_state}; // see RQ22
            `WDS_ADDR_CFG: next_rdata = cfg;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         undervoltage_threshold <= 2'h0;
         sleep_inhibit <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         undervoltage_threshold <= cfg[`WDS_CFG_UV_HI:`WDS_CFG_UV_LO]; // see RQ19
         sleep_inhibit <= cfg[`WDS_CFG_SLP]; // see RQ20
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   early_reset_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ24
      early && !(op_mode == WDS_OP_NORMAL && changed) |=> reset_request && reset_source_code == `WDS_SRC_EARLY)
      else $error("early window trigger did not reset");
   illegal_change_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ7
      trigger && op_mode == WDS_OP_NORMAL && changed |=> reset_request && reset_source_code == `WDS_SRC_ILLEGAL
      && serial_access_failure_event == $past(spi_fail_enable))
      else $error("change in Normal did not force reset");
   // An overflow in the same cycle may request its own reset, so that case is left out here.
   invalid_discard_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ13
      ctrl_wr && !codes_ok && !expiry && op_mode != WDS_OP_RESET |=> $stable(mode_select)
      && $stable(period_select) && !reset_request)
      else $error("invalid code write was not discarded");
   trigger_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ10
      trigger && !early && !(op_mode == WDS_OP_NORMAL && changed) |=> timer == 13'h0000
      && mode_select == $past(reg_wdata[7:5]))
      else $error("trigger did not restart timer");
   forced_off_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ15
      cfg[`WDS_CFG_FNM] |-> wd_state == 2'h0 ##1 (!expiry [*3]))
      else $error("watchdog active in forced normal");
   wdf_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ25
      expiry && eff == WDS_EFF_TIMEOUT && !watchdog_failure_pending |=> watchdog_failure_pending && overflow_wake
      && !reset_request)
      else $error("first timeout expiry did not set failure pending");
   period_default_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ9
      op_mode == WDS_OP_RESET ##1 op_mode == WDS_OP_RESET |-> period_select == `WDS_PER_DEFAULT)
      else $error("period not defaulted in reset");
   sdm_auto_off_a: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ16
      cfg[`WDS_CFG_SDM] && mode_select == `WDS_MODE_AUTO |-> eff == WDS_EFF_OFF)
      else $error("autonomous watchdog running in development mode");

   timeout_expiry_c: cover property (@(posedge mclk) disable iff (!rst_n) expiry && eff == WDS_EFF_TIMEOUT);
   window_late_c: cover property (@(posedge mclk) disable iff (!rst_n)
      trigger && eff == WDS_EFF_WINDOW && !first_half);
   illegal_reset_c: cover property (@(posedge mclk) disable iff (!rst_n)
      reset_request && reset_source_code == `WDS_SRC_ILLEGAL);
   window_overflow_c: cover property (@(posedge mclk) disable iff (!rst_n) expiry && eff == WDS_EFF_WINDOW);
   early_trigger_c: cover property (@(posedge mclk) disable iff (!rst_n) early);

endmodule

// ==== dv/wds_host.sv ====
`timescale 1ns/100ps
module wds_host (
   // Clock.
   input wire logic mclk,
   // Register strobes toward the supervisor.
   output logic reg_wr,
   output logic reg_rd,
   output logic [6:0] reg_addr,
   output logic [7:0] reg_wdata,
   // Read data back.
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h7f;
      reg_wdata = 8'h00;
   end

   // Idle data shows the inverse so a stale value is never mistaken for a fresh one.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
   import wds_pkg::*;
;
   localparam int T = 4;
   localparam int P8 = 8 * T;
   logic mclk;
   logic rst_n;
   logic reg_wr, reg_rd, rxd_pin, spi_fail_enable, failure_clear;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_v, m_ctrl, d;
   wds_op_t op_mode;
   logic reset_request, serial_access_failure_event, overflow_wake, watchdog_failure_pending, sleep_inhibit;
   logic [4:0] reset_source_code;
   logic [1:0] undervoltage_threshold, uv;
   int error_cnt, compares, cyc, n_rst, n_fail, n_wake, t_ev, t0, k, e_fail;

   wds_supervisor #(.TICK_CYCLES(T)) dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .op_mode(op_mode),
      .rxd_pin(rxd_pin), .spi_fail_enable(spi_fail_enable), .failure_clear(failure_clear),
      .reset_request(reset_request), .reset_source_code(reset_source_code),
      .serial_access_failure_event(serial_access_failure_event), .overflow_wake(overflow_wake),
      .watchdog_failure_pending(watchdog_failure_pending), .undervoltage_threshold(undervoltage_threshold),
      .sleep_inhibit(sleep_inhibit));
   wds_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulses stand one cycle, so they are counted at the falling edge.
   always @(negedge mclk) begin
      cyc++;
      if (reset_request === 1'b1) begin
         n_rst++;
         t_ev = cyc;
      end
      if (overflow_wake === 1'b1) begin
         n_wake++;
         t_ev = cyc;
      end
      if (serial_access_failure_event === 1'b1) begin
         n_fail++;
      end
      if (cyc > 5000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task rchk(input string nm, input logic [6:0] a, input logic [7:0] e);
      host.rd(a, rd_v);
      chk(nm, e, rd_v);
   endtask

   task settle;
      repeat (2) @(negedge mclk);
   endtask

   task tdone(input string nm);
      $display("test %s done", nm);
   endtask

   task end_of_test;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      op_mode = WDS_OP_STANDBY;
      rxd_pin = 1'b1;
      spi_fail_enable = 1'b0;
      failure_clear = 1'b0;
      void'($urandom(15));
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      rchk("status", 7'h05, 8'h08);
      rchk("ctrl", 7'h00, 8'h44);
      rchk("cfg", 7'h74, 8'h08);
      rchk("unmapped", 7'h10, 8'h00);
      tdone("reset");
      uv = 2'($urandom_range(3, 0));
      host.wr(7'h74, {2'h3, uv, 4'h7});
      settle();
      chk("uv", {6'h00, uv}, {6'h00, undervoltage_threshold});
      chk("slp", 8'h01, {7'h00, sleep_inhibit});
      rchk("cfg", 7'h74, {2'h0, uv, 4'h5});
      host.wr(7'h74, 8'h00);
      tdone("config");
      // All host writes to the control register in this code test are made in Standby.
      spi_fail_enable = 1'b1;
      m_ctrl = 8'h44;
      e_fail = n_fail;
      k = n_rst;
      for (int c = 0; c < 24; c++) begin
         d = (c < 8) ? {3'(c), 1'($urandom), 4'h8} : {3'h2, 1'($urandom), 4'(c - 8)};
         if (d[7:5] inside {3'h1, 3'h2, 3'h4} &&
             d[3:0] inside {4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7}) begin
            m_ctrl = {d[7:5], 1'b0, d[3:0]};
         end else begin
            e_fail++;
         end
         host.wr(7'h00, d);
         rchk("ctrl", 7'h00, m_ctrl);
      end
      chk("fail_cnt", 8'(e_fail), 8'(n_fail));
      chk("rst_standby", 8'(k), 8'(n_rst));
      spi_fail_enable = 1'b0;
      e_fail = n_fail;
      host.wr(7'h00, 8'h69);
      settle();
      chk("fail_off", 8'(e_fail), 8'(n_fail));
      rchk("ctrl", 7'h00, m_ctrl);
      spi_fail_enable = 1'b1;
      tdone("codes");
      host.wr(7'h00, 8'h48);
      repeat (20) @(negedge mclk);
      host.wr(7'h00, 8'h48);
      t0 = cyc;
      k = n_wake;
      for (int i = 0; i < 200 && n_wake == k; i++) @(negedge mclk);
      #1;
      chk("wake_dt", 8'h01, {7'h00, (t_ev - t0) inside {[P8 - 2:P8 + 3]}});
      chk("wdf", 8'h01, {7'h00, watchdog_failure_pending});
      t0 = t_ev;
      k = n_rst;
      for (int i = 0; i < 200 && n_rst == k; i++) @(negedge mclk);
      #1;
      chk("rst_dt", 8'h01, {7'h00, (t_ev - t0) inside {[P8 - 2:P8 + 3]}});
      chk("src", 8'h0f, {3'h0, reset_source_code});
      @(negedge mclk);
      failure_clear = 1'b1;
      @(negedge mclk);
      failure_clear = 1'b0;
      settle();
      chk("wdf", 8'h00, {7'h00, watchdog_failure_pending});
      tdone("timeout");
      host.wr(7'h00, 8'h88);
      op_mode = WDS_OP_NORMAL;
      repeat (17) @(negedge mclk);
      rchk("state", 7'h05, 8'h02);
      k = n_rst;
      host.wr(7'h00, 8'h88);
      rchk("state", 7'h05, 8'h01);
      chk("late", 8'(k), 8'(n_rst));
      host.wr(7'h00, 8'h88);
      settle();
      chk("early", 8'(k + 1), 8'(n_rst));
      chk("src", 8'h0e, {3'h0, reset_source_code});
      e_fail = n_fail;
      host.wr(7'h00, 8'h81);
      settle();
      chk("illegal", 8'(k + 2), 8'(n_rst));
      chk("src", 8'h10, {3'h0, reset_source_code});
      chk("fail", 8'(e_fail + 1), 8'(n_fail));
      op_mode = WDS_OP_STANDBY;
      rchk("ctrl", 7'h00, 8'h88);
      op_mode = WDS_OP_NORMAL;
      k = n_rst;
      for (int i = 0; i < 200 && n_rst == k; i++) @(negedge mclk);
      chk("overflow", 8'(k + 1), 8'(n_rst));
      chk("src", 8'h0f, {3'h0, reset_source_code});
      op_mode = WDS_OP_STANDBY;
      tdone("window");
      host.wr(7'h00, 8'h28);
      rchk("state", 7'h05, 8'h00);
      rxd_pin = 1'b0;
      repeat (4) @(negedge mclk);
      rchk("state", 7'h05, 8'h01);
      host.wr(7'h74, 8'h04);
      rchk("state", 7'h05, 8'h04);
      op_mode = WDS_OP_RESET;
      repeat (2) @(negedge mclk);
      op_mode = WDS_OP_STANDBY;
      rchk("ctrl", 7'h00, 8'h24);
      host.wr(7'h74, 8'h08);
      host.wr(7'h00, 8'h48);
      op_mode = WDS_OP_NORMAL;
      rchk("state", 7'h05, 8'h08);
      tdone("autonomous");
      end_of_test();
   end
endmodule
